// >>> dv/serial_remote_node.sv
// Remote serial node: sends frames on rxd and decodes frames from txd.
// Assumes eight data bits, no ninth bit and a fixed bit time in clocks.
`timescale 1ns/1ps
module serial_remote_node #(
   parameter int BIT_CYC = 4
)(
   input  wire logic       clk,
   input  wire logic       txd,
   input  wire logic       send,
   input  wire logic [7:0] send_data,
   output logic            rxd,
   output logic            got,
   output logic [7:0]      got_data
);
   // ************************************************************
   // Sender and receiver
   // ************************************************************
   logic [9:0] fr;
   logic [7:0] sh;

   // Line rests at mark between frames, as a pulled-up line would
   initial begin
      rxd = 1'b1;
      forever begin
         @(posedge clk);
         if (send) begin
            fr = {1'b1, send_data, 1'b0};
            for (int i = 0; i < 10; i++) begin
               rxd <= fr[i];
               repeat (BIT_CYC) @(posedge clk);
            end
         end
      end
   end

   // Mid-bit sampling tolerates a cycle or two of launch skew
   initial begin
      got      = 1'b0;
      got_data = 8'h00;
      forever begin
         @(negedge txd);
         repeat (BIT_CYC / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            sh[i] = txd;
         end
         repeat (BIT_CYC) @(posedge clk);
         if (txd === 1'b1) begin
            got_data <= sh;
            got      <= 1'b1;
         end
         @(posedge clk);
         got <= 1'b0;
      end
   end
endmodule : serial_remote_node

// >>> dv/serial_status_flags_test.sv
// Self-checking bench of the serial status flags with a remote node.
// Assumes a bit time of baud+1 clocks with the reset baud value kept.
`timescale 1ns/1ps
module serial_status_flags_test;
   import serial_status_pkg::*;
   localparam int BIT_CYC = 4;
   logic       SYS_CLK, RST_N, WR, RD, RXD, TXD, IRQ, send, got;
   logic [7:0] ADDR, WDATA, RDATA, send_data, got_data, r, b;
   int         errors, checked;
   logic [7:0] tx_q[$], seen_q[$];

   serial_status_flags u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
   serial_remote_node #(.BIT_CYC(BIT_CYC)) u_node (.clk(SYS_CLK),
      .txd(TXD), .send(send), .send_data(send_data), .rxd(RXD),
      .got(got), .got_data(got_data));

   // ************************************************************
   // Clock, collection and bus tasks
   // ************************************************************
   initial begin
      SYS_CLK = 1'b0;
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end

   always @(posedge SYS_CLK) begin
      if (got === 1'b1) seen_q.push_back(got_data);
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge SYS_CLK);
      WR    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge SYS_CLK);
      RD   <= 1'b0;
      #1 d = RDATA;
   endtask : rd

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask : chk

   task automatic st(input logic [7:0] e);
      rd(OFS_STATUS_ONE, r);
      chk("status", e, r);
   endtask : st

   task automatic rx(input logic [7:0] d);
      @(posedge SYS_CLK);
      send      <= 1'b1;
      send_data <= d;
      @(posedge SYS_CLK);
      send      <= 1'b0;
      repeat (11 * BIT_CYC) @(posedge SYS_CLK);
   endtask : rx

   task automatic stop_test;
      if (errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test

   initial begin
      repeat (20000) @(posedge SYS_CLK);
      errors++;
      stop_test();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      errors = 0;
      checked = 0;
      b = 8'($urandom(91343));
      {RST_N, WR, RD, ADDR, WDATA, send, send_data} = '0;
      repeat (20) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      st(8'hc0);
      rd(OFS_BAUD, r);
      chk("baud", 8'h03, r);
      wr(OFS_STATUS_ONE, 8'h00);
      st(8'hc0);
      rd(8'h1c, r);
      chk("unmapped", 8'h00, r);
      // Data write after an arming status read; the shifter reloads empty
      tx_q.push_back(b);
      wr(OFS_DATA_LOW, b);
      st(8'h80);
      repeat (12 * BIT_CYC) @(posedge SYS_CLK);
      st(8'hc0);
      chk("txd_idle", 8'h01, {7'h00, TXD});
      // Second byte lands while the first is still shifting out
      st(8'hc0);
      for (int i = 0; i < 2; i++) begin
         b = 8'($urandom());
         tx_q.push_back(b);
         wr(OFS_DATA_LOW, b);
         if (i == 0) st(8'h80);
      end
      st(8'h00);
      repeat (25 * BIT_CYC) @(posedge SYS_CLK);
      st(8'hc0);
      chk("tx_count", 8'(tx_q.size()), 8'(seen_q.size()));
      foreach (tx_q[i]) chk("tx_byte", tx_q[i], seen_q[i]);
      // Receive with only the receive-full event unmasked
      wr(OFS_MASK, 8'h20);
      #1 chk("irq_masked", 8'h00, {7'h00, IRQ});
      // Top data bit a space: idle cannot come before the event checks
      b = {1'b0, 7'($urandom())};
      rx(b);
      #1 chk("irq", 8'h01, {7'h00, IRQ});
      rd(OFS_DATA_LOW, r);
      chk("rx_byte", b, r);
      st(8'he0);
      rd(OFS_DATA_LOW, r);
      st(8'hc0);
      rd(OFS_EVENT, r);
      chk("event", 8'he0, r);
      wr(OFS_EVENT, 8'hff);
      repeat (2) @(posedge SYS_CLK);
      #1 chk("irq_clr", 8'h00, {7'h00, IRQ});
      repeat (12 * BIT_CYC) @(posedge SYS_CLK);
      st(8'hd0);
      rd(OFS_DATA_LOW, r);
      st(8'hc0);
      rd(OFS_DATA_LOW, r);
      repeat (14 * BIT_CYC) @(posedge SYS_CLK);
      st(8'hc0);
      // Receiver wakeup set: a fresh frame then idle must not flag idle
      wr(OFS_CTRL, 8'h02);
      rx(8'($urandom()));
      repeat (14 * BIT_CYC) @(posedge SYS_CLK);
      st(8'he0);
      // Break request: complete drops at once and no byte reaches the node
      wr(OFS_CTRL, 8'h04);
      st(8'ha0);
      repeat (12 * BIT_CYC) @(posedge SYS_CLK);
      st(8'he0);
      chk("brk_none", 8'(tx_q.size()), 8'(seen_q.size()));
      stop_test();
   end
endmodule : serial_status_flags_test

// >>> logic/serial_rx_shift.sv
// Receive shifter and idle-line counter.
// Assumes rxd is already synchronised to clk.
`timescale 1ns/1ps
module serial_rx_shift
   import serial_status_pkg::*;
#(
   parameter int unsigned DIV_W = 8
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             rxd,
   input  wire logic             word_len,
   input  wire logic [3:0]       frame_bits,
   input  wire logic [DIV_W-1:0] div,
   output logic                  done,
   output logic [8:0]            data,
   output logic                  idle_hit
);
   generate
      if (DIV_W < 2) begin : g_chk
         $error("serial_rx_shift: DIV_W below 2");
      end
   endgenerate

   rx_state_t        state_q;
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] ones_cnt_q;
   logic [3:0]       left_q;
   logic [3:0]       ones_bits_q;
   logic [9:0]       sh_q;
   logic [9:0]       full_w;
   logic [8:0]       data_q;
   logic             done_q;
   logic             hit_q;

   assign full_w = {rxd, sh_q[9:1]};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= RX_IDLE;
         cnt_q   <= '0;
         left_q  <= '0;
         sh_q    <= '0;
         data_q  <= '0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            RX_IDLE: begin
               if (!rxd) begin
                  state_q <= RX_START;
                  cnt_q   <= div >> 1;
               end
            end
            RX_START: begin
               // Start bit rechecked mid-bit to reject glitches
               if (cnt_q == '0) begin
                  state_q <= rxd ? RX_IDLE : RX_BITS;
                  cnt_q   <= div;
                  left_q  <= frame_bits - 4'h1;
               end else begin
                  cnt_q <= cnt_q - DIV_W'(1);
               end
            end
            RX_BITS: begin
               if (cnt_q == '0) begin
                  sh_q   <= full_w;
                  cnt_q  <= div;
                  left_q <= left_q - 4'h1;
                  if (left_q == 4'h1) begin
                     state_q <= RX_IDLE;
                     done_q  <= rxd;
                     if (rxd) begin
                        data_q <= word_len ? full_w[8:0]
                                           : {1'b0, full_w[8:1]};
                     end
                  end
               end else begin
                  cnt_q <= cnt_q - DIV_W'(1);
               end
            end
            default: state_q <= RX_IDLE;
         endcase
      end
   end

   // Counts whole bit times of mark level; saturates until a space
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ones_cnt_q  <= '0;
         ones_bits_q <= '0;
         hit_q       <= 1'b0;
      end else begin
         hit_q <= 1'b0;
         if (!rxd) begin
            ones_cnt_q  <= '0;
            ones_bits_q <= '0;
         end else if (ones_bits_q != frame_bits) begin
            if (ones_cnt_q == div) begin
               ones_cnt_q  <= '0;
               ones_bits_q <= ones_bits_q + 4'h1;
               hit_q       <= (ones_bits_q + 4'h1 == frame_bits);
            end else begin
               ones_cnt_q <= ones_cnt_q + DIV_W'(1);
            end
         end
      end
   end

   assign done     = done_q;
   assign data     = data_q;
   assign idle_hit = hit_q;

endmodule : serial_rx_shift

// >>> logic/serial_status_flags.sv
// Serial interface status flags with register port, shifters and irq.
// Assumes a single-cycle register master and an asynchronous RXD pin.
//
// Overview of operation
// - Apart from complete on queueing, a flag clears only by a status read first, then a data access.
// - Transmit-empty (bit 7) sets when the shifter takes the data byte.
// - Transmit-empty clears by a status read that saw it, then a data write.
// - Transmit-complete (bit 6) stays low while anything is being sent.
// - Transmit-complete sets when sending ends; then the line idles high.
// - Transmit-complete clears by the sequence or once anything is queued.
// - When transmit-complete sees set and clear together, clear wins.
// - Receive-full (bit 5) sets when a received byte reaches the data reg.
// - Receive-full clears by a status read that saw it, then a data read.
// - Idle (bit 4) sets after 10 mark bit times, or 11 with long words.
// - After idle clears it cannot set again until receive-full has set.
// - Idle clears by a status read that saw it, then a data read.
// - While receiver wakeup is set, an idle line does not set idle.
// - Status at offset 0x0004 reads at any time; writes do nothing.
// - The flags are both pollable bits and interrupt sources.
`timescale 1ns/1ps
module serial_status_flags
   import serial_status_pkg::*;
(
   input  wire logic              SYS_CLK,
   input  wire logic              RST_N,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic       [DATA_W-1:0] RDATA,
   input  wire logic              RXD,
   output logic                   TXD,
   output logic                   IRQ
);

   // ************************************************************
   // Register decode
   // ************************************************************
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction : hit

   logic wr_ctrl;
   logic wr_data;
   logic wr_baud;
   logic wr_event;
   logic wr_mask;
   logic rd_status;
   logic rd_data;

   assign wr_ctrl   = WR & hit(ADDR, OFS_CTRL);
   assign wr_data   = WR & hit(ADDR, OFS_DATA_LOW);
   assign wr_baud   = WR & hit(ADDR, OFS_BAUD);
   assign wr_event  = WR & hit(ADDR, OFS_EVENT);
   assign wr_mask   = WR & hit(ADDR, OFS_MASK);
   assign rd_status = RD & hit(ADDR, OFS_STATUS_ONE);
   assign rd_data   = RD & hit(ADDR, OFS_DATA_LOW);

   ctrl_t      ctrl_q;
   ctrl_t      ctrl_w;
   logic [7:0] baud_q;
   logic [7:0] mask_q;
   logic [7:0] event_q;
   logic [8:0] tx_data_q;
   logic       brk_req;
   logic       pre_req;

   assign ctrl_w  = ctrl_t'(WDATA);
   assign brk_req = wr_ctrl & ctrl_w.brk_req;
   assign pre_req = wr_ctrl & ctrl_w.pre_req;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         ctrl_q <= ctrl_t'(RST_CTRL);
         baud_q <= RST_BAUD;
         mask_q <= RST_MASK;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= ctrl_t'(WDATA & CTRL_KEEP);
         end
         if (wr_baud) begin
            baud_q <= WDATA;
         end
         if (wr_mask) begin
            mask_q <= WDATA;
         end
      end
   end

   // ************************************************************
   // Receive side
   // ************************************************************
   logic       rxd_meta_q;
   logic       rxd_sync_q;
   logic       rx_done;
   logic       idle_hit;
   logic [8:0] rx_data;
   logic [3:0] frame_bits;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rxd_meta_q <= 1'b1;
         rxd_sync_q <= 1'b1;
      end else begin
         rxd_meta_q <= RXD;
         rxd_sync_q <= rxd_meta_q;
      end
   end

   assign frame_bits = ctrl_q.word_len ? FRAME_BITS_M1 : FRAME_BITS_M0;

   serial_rx_shift #(
      .DIV_W      (8)
   ) u_rx (
      .clk        (SYS_CLK),
      .rst_n      (RST_N),
      .rxd        (rxd_sync_q),
      .word_len   (ctrl_q.word_len),
      .frame_bits (frame_bits),
      .div        (baud_q),
      .done       (rx_done),
      .data       (rx_data),
      .idle_hit   (idle_hit)
   );

   // ************************************************************
   // Transmit queue and shifter
   // ************************************************************
   logic        tx_pend_q;
   logic        brk_pend_q;
   logic        pre_pend_q;
   logic        tx_busy;
   logic        tx_busy_q;
   logic        launch_brk;
   logic        launch_pre;
   logic        launch_data;
   logic        queued;
   logic [10:0] tx_frame;

   // Break first, then preamble, then data; one launch per idle shifter
   assign launch_brk  = !tx_busy & brk_pend_q;
   assign launch_pre  = !tx_busy & !brk_pend_q & pre_pend_q;
   assign launch_data = !tx_busy & !brk_pend_q & !pre_pend_q & tx_pend_q;
   assign queued      = tx_pend_q | brk_pend_q | pre_pend_q
                      | wr_data | brk_req | pre_req;

   always_comb begin
      if (launch_brk) begin
         tx_frame = FRAME_BREAK;
      end else if (launch_pre) begin
         tx_frame = FRAME_PREAMBLE;
      end else if (ctrl_q.word_len) begin
         tx_frame = {1'b1, tx_data_q, 1'b0};
      end else begin
         // Short frames put the stop bit where the ninth bit would go
         tx_frame = {2'b11, tx_data_q[7:0], 1'b0};
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         tx_pend_q  <= 1'b0;
         brk_pend_q <= 1'b0;
         pre_pend_q <= 1'b0;
         tx_data_q  <= '0;
         tx_busy_q  <= 1'b0;
      end else begin
         tx_busy_q  <= tx_busy;
         // A new request in the launch cycle stays pending
         tx_pend_q  <= wr_data | (tx_pend_q & !launch_data);
         brk_pend_q <= brk_req | (brk_pend_q & !launch_brk);
         pre_pend_q <= pre_req | (pre_pend_q & !launch_pre);
         if (wr_data) begin
            tx_data_q <= {ctrl_q.tx_ninth, WDATA};
         end
      end
   end

   serial_tx_shift #(
      .FRAME_W    (11),
      .DIV_W      (8)
   ) u_tx (
      .clk        (SYS_CLK),
      .rst_n      (RST_N),
      .load       (launch_brk | launch_pre | launch_data),
      .frame      (tx_frame),
      .frame_bits (frame_bits),
      .div        (baud_q),
      .busy       (tx_busy),
      .txd        (TXD)
   );

   // ************************************************************
   // Status flags and two-step clearing
   // ************************************************************
   logic       tx_empty_q;
   logic       tx_done_q;
   logic       rx_full_q;
   logic       idle_q;
   logic       idle_armed_q;
   logic [7:0] arm_q;
   logic [7:0] flags;
   logic       tx_done_set;
   logic       tx_done_clr;
   logic       tx_empty_clr;
   logic       rx_full_clr;
   logic       idle_clr;
   logic       idle_set;
   serial_status_one_t status_w;

   assign status_w = '{transmit_empty_flag:    tx_empty_q,
                       transmit_complete_flag: tx_done_q,
                       receive_full_flag:      rx_full_q,
                       idle_flag:              idle_q,
                       rsvd:                   4'h0};
   assign flags    = status_w;

   // Apart from complete on a queued request, only flags seen set by the last status read may be cleared
   assign tx_empty_clr = wr_data & arm_q[BIT_TX_EMPTY];
   assign tx_done_clr  = (wr_data & arm_q[BIT_TX_DONE]) | queued;
   assign rx_full_clr  = rd_data & arm_q[BIT_RX_FULL];
   assign idle_clr     = rd_data & arm_q[BIT_IDLE];
   assign tx_done_set  = tx_busy_q & !tx_busy & tx_empty_q;
   assign idle_set     = idle_hit & idle_armed_q & !ctrl_q.receiver_wakeup;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         arm_q <= '0;
      end else if (rd_status) begin
         arm_q <= flags;
      end else begin
         arm_q <= arm_q & flags
                & ~({8{wr_data}} & 8'hc0)
                & ~({8{rd_data}} & 8'h30);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         tx_empty_q <= 1'b1;
      end else if (launch_data) begin
         tx_empty_q <= 1'b1;
      end else if (tx_empty_clr) begin
         tx_empty_q <= 1'b0;
      end
   end

   // Clear is tested first here: a set in the same cycle loses
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         tx_done_q <= 1'b1;
      end else if (tx_done_clr) begin
         tx_done_q <= 1'b0;
      end else if (tx_done_set) begin
         tx_done_q <= 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rx_full_q <= 1'b0;
      end else if (rx_done) begin
         rx_full_q <= 1'b1;
      end else if (rx_full_clr) begin
         rx_full_q <= 1'b0;
      end
   end

   // Idle rearms only after a good frame sets receive-full
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         idle_q       <= 1'b0;
         idle_armed_q <= 1'b0;
      end else begin
         if (idle_set) begin
            idle_q <= 1'b1;
         end else if (idle_clr) begin
            idle_q <= 1'b0;
         end
         if (rx_done) begin
            idle_armed_q <= 1'b1;
         end else if (idle_clr & !idle_set) begin
            idle_armed_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Events, interrupt and read data
   // ************************************************************
   logic [7:0] ev_set;
   logic [7:0] rdata_q;
   logic       irq_q;

   assign ev_set = {launch_data, tx_done_set & !tx_done_clr, rx_done, idle_set,
                    4'h0};

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         event_q <= '0;
         irq_q   <= 1'b0;
      end else begin
         // Set beats a simultaneous write-one-to-clear
         event_q <= ev_set | (event_q & ~({8{wr_event}} & WDATA));
         irq_q   <= |(event_q & mask_q);
      end
   end

   // Writes to the status offset fall through: no storage behind it
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rdata_q <= '0;
      end else if (RD) begin
         case (ADDR)
            OFS_CTRL:       rdata_q <= ctrl_q;
            OFS_STATUS_ONE: rdata_q <= flags;
            OFS_DATA_LOW:   rdata_q <= rx_data[7:0];
            OFS_BAUD:       rdata_q <= baud_q;
            OFS_EVENT:      rdata_q <= event_q;
            OFS_MASK:       rdata_q <= mask_q;
            default:        rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   assign RDATA = rdata_q;
   assign IRQ   = irq_q;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   property p_tx_empty_set;
      launch_data |=> tx_empty_q;
   endproperty
   a_tx_empty_set: assert property (p_tx_empty_set)
      else $error("transmit empty not set after load");

   property p_tx_done_low_busy;
      tx_busy |-> !tx_done_q;
   endproperty
   a_tx_done_low_busy: assert property (p_tx_done_low_busy)
      else $error("transmit complete high while sending");

   property p_tx_done_idle_line;
      tx_done_q |-> TXD;
   endproperty
   a_tx_done_idle_line: assert property (p_tx_done_idle_line)
      else $error("line not idle while transmit complete");

   property p_tx_done_clear_wins;
      (tx_done_set && tx_done_clr) |=> !tx_done_q;
   endproperty
   a_tx_done_clear_wins: assert property (p_tx_done_clear_wins)
      else $error("transmit complete set despite clear");

   property p_rx_full_set;
      rx_done |=> rx_full_q;
   endproperty
   a_rx_full_set: assert property (p_rx_full_set)
      else $error("receive full not set after frame");

   property p_rx_full_clear;
      (rd_data && arm_q[BIT_RX_FULL] && !rx_done) |=> !rx_full_q;
   endproperty
   a_rx_full_clear: assert property (p_rx_full_clear)
      else $error("receive full not cleared by sequence");

   property p_idle_unarmed;
      (idle_hit && !idle_armed_q && !idle_q) |=> !idle_q;
   endproperty
   a_idle_unarmed: assert property (p_idle_unarmed)
      else $error("idle set without prior received frame");

   property p_idle_wakeup;
      (idle_hit && ctrl_q.receiver_wakeup && !idle_q) |=> !idle_q;
   endproperty
   a_idle_wakeup: assert property (p_idle_wakeup)
      else $error("idle set while receiver wakeup");

   property p_status_read;
      rd_status |=> (RDATA == $past(flags));
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read data wrong");

   property p_no_arm_keep;
      (wr_data && !arm_q[BIT_TX_EMPTY] && !launch_data)
         |=> tx_empty_q == $past(tx_empty_q);
   endproperty
   a_no_arm_keep: assert property (p_no_arm_keep)
      else $error("transmit empty changed without status read");

endmodule : serial_status_flags

// >>> logic/serial_status_pkg.sv
// Shared constants and types of the serial status flag block.
// Assumes a byte-wide register port with byte addresses.
package serial_status_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned DATA_W         = 8;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_STATUS_ONE = 8'h04;
   localparam logic [7:0]  OFS_DATA_LOW   = 8'h08;
   localparam logic [7:0]  OFS_BAUD       = 8'h0c;
   localparam logic [7:0]  OFS_EVENT      = 8'h10;
   localparam logic [7:0]  OFS_MASK       = 8'h14;

   // Flag positions in the status register, event and mask registers
   localparam int unsigned BIT_TX_EMPTY   = 7;
   localparam int unsigned BIT_TX_DONE    = 6;
   localparam int unsigned BIT_RX_FULL    = 5;
   localparam int unsigned BIT_IDLE       = 4;

   // Control bits kept in storage; break and preamble bits only queue
   localparam logic [7:0]  CTRL_KEEP      = 8'h13;

   // ************************************************************
   // Reset values and frame shapes
   // ************************************************************
   localparam logic [7:0]  RST_CTRL       = 8'h00;
   localparam logic [7:0]  RST_BAUD       = 8'h03;
   localparam logic [7:0]  RST_MASK       = 8'h00;
   localparam logic [3:0]  FRAME_BITS_M0  = 4'ha;
   localparam logic [3:0]  FRAME_BITS_M1  = 4'hb;
   localparam logic [10:0] FRAME_BREAK    = 11'h000;
   localparam logic [10:0] FRAME_PREAMBLE = 11'h7ff;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b01,
      TX_SHIFT = 2'b10
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_START = 3'b010,
      RX_BITS  = 3'b100
   } rx_state_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic       tx_ninth;
      logic       pre_req;
      logic       brk_req;
      logic       receiver_wakeup;
      logic       word_len;
   } ctrl_t;

   typedef struct packed {
      logic       transmit_empty_flag;
      logic       transmit_complete_flag;
      logic       receive_full_flag;
      logic       idle_flag;
      logic [3:0] rsvd;
   } serial_status_one_t;

endpackage : serial_status_pkg

// >>> logic/serial_tx_shift.sv
// Transmit shifter: sends one prepared frame LSB first.
// Assumes the caller loads only while busy is low.
`timescale 1ns/1ps
module serial_tx_shift
   import serial_status_pkg::*;
#(
   parameter int unsigned FRAME_W = 11,
   parameter int unsigned DIV_W   = 8
)(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               load,
   input  wire logic [FRAME_W-1:0] frame,
   input  wire logic [3:0]         frame_bits,
   input  wire logic [DIV_W-1:0]   div,
   output logic                    busy,
   output logic                    txd
);
   generate
      if (FRAME_W < 11) begin : g_chk
         $error("serial_tx_shift: FRAME_W below 11");
      end
   endgenerate

   tx_state_t          state_q;
   logic [FRAME_W-1:0] shift_q;
   logic [3:0]         left_q;
   logic [DIV_W-1:0]   cnt_q;
   logic               txd_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= TX_IDLE;
         shift_q <= '1;
         left_q  <= '0;
         cnt_q   <= '0;
         txd_q   <= 1'b1;
      end else begin
         case (state_q)
            TX_IDLE: begin
               if (load) begin
                  state_q <= TX_SHIFT;
                  shift_q <= frame;
                  left_q  <= frame_bits;
                  cnt_q   <= div;
                  txd_q   <= frame[0];
               end
            end
            TX_SHIFT: begin
               if (cnt_q == '0) begin
                  if (left_q == 4'h1) begin
                     // Line returns to mark level as the frame ends
                     state_q <= TX_IDLE;
                     txd_q   <= 1'b1;
                  end else begin
                     shift_q <= {1'b1, shift_q[FRAME_W-1:1]};
                     txd_q   <= shift_q[1];
                     left_q  <= left_q - 4'h1;
                     cnt_q   <= div;
                  end
               end else begin
                  cnt_q <= cnt_q - DIV_W'(1);
               end
            end
            default: state_q <= TX_IDLE;
         endcase
      end
   end

   assign busy = (state_q == TX_SHIFT);
   assign txd  = txd_q;

endmodule : serial_tx_shift
